//--- logic/pwmoal_pkg.sv
// Purpose: Constants and types for the PWM output action logic
// Assumes: APB slave, 32-bit data, three generators
// Notes:   Offsets are byte addresses
package pwmoal_pkg;
    localparam int          NUM_GEN        = 3;            // Generators in the unit
    localparam logic [11:0] GEN0_A_OFF     = 12'h060;      // Gen 0 A action control
    localparam logic [11:0] GEN0_B_OFF     = 12'h064;      // Gen 0 B action control
    localparam logic [11:0] GEN1_A_OFF     = 12'h0A0;      // Gen 1 A action control
    localparam logic [11:0] GEN1_B_OFF     = 12'h0A4;      // Gen 1 B action control
    localparam logic [11:0] GEN2_A_OFF     = 12'h0E0;      // Gen 2 A action control
    localparam logic [11:0] GEN2_B_OFF     = 12'h0E4;      // Gen 2 B action control
    localparam logic [11:0] MODE_OFF       = 12'h100;      // Up/down mode bits, one per gen
    localparam logic [11:0] OUT_STAT_OFF   = 12'h104;      // Output level status
    localparam int          ZERO_LSB       = 0;            // Bottom value action field
    localparam int          LOAD_LSB       = 2;            // Top value action field
    localparam int          CAU_LSB        = 4;            // Cmp A upward field
    localparam int          CAD_LSB        = 6;            // Cmp A downward field
    localparam int          CBU_LSB        = 8;            // Cmp B upward field
    localparam int          CBD_LSB        = 10;           // Cmp B downward field
    localparam int          CTRL_W         = 12;           // Implemented control bits
    localparam logic [11:0] CTRL_RST       = 12'h000;      // All fields no-change
    localparam logic [1:0]  ACT_NONE       = 2'h0;         // Leave output
    localparam logic [1:0]  ACT_TOGGLE     = 2'h1;         // Invert output
    localparam logic [1:0]  ACT_LOW        = 2'h2;         // Drive low
    localparam logic [1:0]  ACT_HIGH       = 2'h3;         // Drive high

    // Event pulses of one generator
    typedef struct packed {
        logic zero;    // Counter at zero
        logic load;    // Counter at load
        logic cmp_a;   // Comparator A match
        logic cmp_b;   // Comparator B match
        logic dir_up;  // Counting upward this cycle
    } pwmoal_evt_t;
endpackage : pwmoal_pkg

//--- logic/pwmoal_top.sv
// Purpose: Output action logic for three PWM generators with APB registers
// Assumes: Event pulses are one pclk cycle wide and synchronous to pclk
// Notes:   Zero-wait APB slave; unmapped reads return zero, pslverr low
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module pwmoal_top (
    input  wire logic                            pclk,        // APB clock
    input  wire logic                            presetn,     // Async reset, low
    input  wire logic                            psel,        // APB select
    input  wire logic                            penable,     // APB enable
    input  wire logic                            pwrite,      // APB direction
    input  wire logic [11:0]                     paddr,       // APB byte address
    input  wire logic [31:0]                     pwdata,      // APB write data
    output logic      [31:0]                     prdata,      // APB read data
    output logic                                 pready,      // APB ready
    output logic                                 pslverr,     // APB error
    input  wire pwmoal_pkg::pwmoal_evt_t [2:0]   gen_evt,     // Per-generator events
    output logic      [2:0]                      generator_first_output,  // A outputs
    output logic      [2:0]                      generator_second_output  // B outputs
);
    import pwmoal_pkg::*;

    logic [CTRL_W-1:0] a_ctrl_reg [NUM_GEN];   // A action controls
    logic [CTRL_W-1:0] a_ctrl_next [NUM_GEN];
    logic [CTRL_W-1:0] b_ctrl_reg [NUM_GEN];   // B action controls
    logic [CTRL_W-1:0] b_ctrl_next [NUM_GEN];
    logic [2:0]        mode_reg;               // Up/down mode per generator
    logic [2:0]        mode_next;
    logic [31:0]       prdata_next;            // Read word captured in setup
    logic              out_a_next [NUM_GEN];   // Next A output levels
    logic              out_b_next [NUM_GEN];   // Next B output levels

    logic wr_en;   // Write takes effect in access phase
    logic rd_en;   // Read data captured in setup phase
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    // Apply one two-bit action code to an output level
    function automatic logic apply_act(input logic [1:0] act, input logic cur);
        unique case (act)
            ACT_NONE:   apply_act = cur;
            ACT_TOGGLE: apply_act = ~cur;
            ACT_LOW:    apply_act = 1'b0;
            ACT_HIGH:   apply_act = 1'b1;
        endcase
    endfunction : apply_act

    // Priority: zero, then load, then the output's own comparator; the
    // losing actions of a cycle are dropped, never queued for later.
    // Pick the single winning action of one output
    function automatic logic [1:0] pick_act(input logic [CTRL_W-1:0] c,
                                            input pwmoal_evt_t e,
                                            input logic up_mode,
                                            input logic b_first);
        logic up;
        logic ca;
        logic cb;
        logic [1:0] a_act;
        logic [1:0] b_act;
        up    = up_mode & e.dir_up;
        ca    = e.cmp_a;
        cb    = e.cmp_b;
        a_act = up ? c[CAU_LSB +: 2] : c[CAD_LSB +: 2];
        b_act = up ? c[CBU_LSB +: 2] : c[CBD_LSB +: 2];
        if (e.zero) begin
            pick_act = c[ZERO_LSB +: 2];
        end else if (e.load) begin
            pick_act = c[LOAD_LSB +: 2];
        end else if (ca && cb) begin
            pick_act = b_first ? b_act : a_act;
        end else if (ca) begin
            pick_act = a_act;
        end else if (cb) begin
            pick_act = b_act;
        end else begin
            pick_act = ACT_NONE;
        end
    endfunction : pick_act

    // Read data is captured in the setup phase and held through access, so
    // the word that software sees cannot change under the completing edge.
    // Register writes and read mux
    always_comb begin
        mode_next   = mode_reg;
        prdata_next = 32'h0000_0000;
        for (int g = 0; g < NUM_GEN; g++) begin
            a_ctrl_next[g] = a_ctrl_reg[g];
            b_ctrl_next[g] = b_ctrl_reg[g];
        end
        if (wr_en) begin
            unique case (paddr)
                GEN0_A_OFF: a_ctrl_next[0] = pwdata[CTRL_W-1:0];
                GEN1_A_OFF: a_ctrl_next[1] = pwdata[CTRL_W-1:0];
                GEN2_A_OFF: a_ctrl_next[2] = pwdata[CTRL_W-1:0];
                GEN0_B_OFF: b_ctrl_next[0] = pwdata[CTRL_W-1:0];
                GEN1_B_OFF: b_ctrl_next[1] = pwdata[CTRL_W-1:0];
                GEN2_B_OFF: b_ctrl_next[2] = pwdata[CTRL_W-1:0];
                MODE_OFF:   mode_next      = pwdata[2:0];
                default:    ;                                      // Ignored
            endcase
        end
        if (rd_en) begin
            unique case (paddr)
                GEN0_A_OFF:   prdata_next = {20'h00000, a_ctrl_reg[0]};
                GEN1_A_OFF:   prdata_next = {20'h00000, a_ctrl_reg[1]};
                GEN2_A_OFF:   prdata_next = {20'h00000, a_ctrl_reg[2]};
                GEN0_B_OFF:   prdata_next = {20'h00000, b_ctrl_reg[0]};
                GEN1_B_OFF:   prdata_next = {20'h00000, b_ctrl_reg[1]};
                GEN2_B_OFF:   prdata_next = {20'h00000, b_ctrl_reg[2]};
                MODE_OFF:     prdata_next = {29'h0000_0000, mode_reg};
                OUT_STAT_OFF: prdata_next = {26'h000_0000, generator_second_output,
                                             generator_first_output};
                default:      prdata_next = 32'h0000_0000;
            endcase
        end else begin
            prdata_next = prdata;   // Hold through access phase
        end
    end

    // Output action next values, one identical slice per generator.
    // The winning code is resolved first so that at most one action
    // reaches each output register in a cycle.
    for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
        logic [1:0] act_a;   // Winning code for the A output
        logic [1:0] act_b;   // Winning code for the B output
        // Resolve priorities, then apply the winning code
        always_comb begin
            act_a         = pick_act(a_ctrl_reg[g], gen_evt[g], mode_reg[g], 1'b0);
            act_b         = pick_act(b_ctrl_reg[g], gen_evt[g], mode_reg[g], 1'b1);
            out_a_next[g] = apply_act(act_a, generator_first_output[g]);
            out_b_next[g] = apply_act(act_b, generator_second_output[g]);
        end
    end : g_gen

    // State registers; every top-level output is a flop set here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                a_ctrl_reg[g] <= CTRL_RST;
                b_ctrl_reg[g] <= CTRL_RST;
            end
            mode_reg                <= 3'h0;
            prdata                  <= 32'h0000_0000;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
            generator_first_output  <= 3'h0;
            generator_second_output <= 3'h0;
        end else begin
            for (int g = 0; g < NUM_GEN; g++) begin
                a_ctrl_reg[g] <= a_ctrl_next[g];
                b_ctrl_reg[g] <= b_ctrl_next[g];
            end
            mode_reg                <= mode_next;
            prdata                  <= prdata_next;
            pready                  <= psel & ~penable;     // Ready in access phase
            pslverr                 <= 1'b0;
            for (int g = 0; g < NUM_GEN; g++) begin
                generator_first_output[g]  <= out_a_next[g];
                generator_second_output[g] <= out_b_next[g];
            end
        end
    end

    // Assertions
    // Each one names every higher-priority event as absent, so it only fires
    // when the guarded action is the one that must win. The bench drives
    // the slices named here with the codes that make each antecedent true.

    // A zero event with the high code drives B0 high
    a_zero_wins_b: assert property (@(posedge pclk) disable iff (!presetn)
        (gen_evt[0].zero && b_ctrl_reg[0][ZERO_LSB +: 2] == ACT_HIGH)
        |=> generator_second_output[0])
        else $error("zero action not applied on B0");

    // A zero event with the low code drives B0 low
    a_zero_low_b: assert property (@(posedge pclk) disable iff (!presetn)
        (gen_evt[0].zero && b_ctrl_reg[0][ZERO_LSB +: 2] == ACT_LOW)
        |=> !generator_second_output[0])
        else $error("low code not applied on B0");

    // The no-change code leaves B0 where it was
    a_zero_keep_b: assert property (@(posedge pclk) disable iff (!presetn)
        (gen_evt[0].zero && b_ctrl_reg[0][ZERO_LSB +: 2] == ACT_NONE)
        |=> $stable(generator_second_output[0]))
        else $error("no-change code moved B0");

    // The toggle code inverts B0
    a_toggle_b: assert property (@(posedge pclk) disable iff (!presetn)
        (gen_evt[0].zero && b_ctrl_reg[0][ZERO_LSB +: 2] == ACT_TOGGLE)
        |=> generator_second_output[0] != $past(generator_second_output[0]))
        else $error("toggle failed on B0");

    // A zero event with the high code drives A1 high
    a_zero_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (gen_evt[1].zero && a_ctrl_reg[1][ZERO_LSB +: 2] == ACT_HIGH)
        |=> generator_first_output[1])
        else $error("zero action not applied on A1");

    // A load event without zero, with the low code, drives A1 low
    a_load_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[1].zero && gen_evt[1].load && a_ctrl_reg[1][LOAD_LSB +: 2] == ACT_LOW)
        |=> !generator_first_output[1])
        else $error("load action not applied on A1");

    // Load beats a coinciding compare B on B1
    a_load_beats_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[1].zero && gen_evt[1].load && gen_evt[1].cmp_b
         && b_ctrl_reg[1][LOAD_LSB +: 2] == ACT_HIGH)
        |=> generator_second_output[1])
        else $error("load did not beat compare on B1");

    // Compare B alone in down counting uses the B downward field on B1
    a_cmpb_down_b: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[1].zero && !gen_evt[1].load && !gen_evt[1].cmp_a && gen_evt[1].cmp_b
         && !mode_reg[1] && b_ctrl_reg[1][CBD_LSB +: 2] == ACT_LOW)
        |=> !generator_second_output[1])
        else $error("cmp B downward action missed on B1");

    // Coinciding compares: the B output takes the B action
    a_b_over_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[2].zero && !gen_evt[2].load && gen_evt[2].cmp_a && gen_evt[2].cmp_b
         && !mode_reg[2] && b_ctrl_reg[2][CBD_LSB +: 2] == ACT_HIGH)
        |=> generator_second_output[2])
        else $error("cmp B did not win on B2");

    // Coinciding compares: the A output takes the A action
    a_a_over_b: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[2].zero && !gen_evt[2].load && gen_evt[2].cmp_a && gen_evt[2].cmp_b
         && !mode_reg[2] && a_ctrl_reg[2][CAD_LSB +: 2] == ACT_HIGH)
        |=> generator_first_output[2])
        else $error("cmp A did not win on A2");

    // Compare A upward toggles A0 in up/down counting
    a_up_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[0].zero && !gen_evt[0].load && gen_evt[0].cmp_a && !gen_evt[0].cmp_b
         && mode_reg[0] && gen_evt[0].dir_up && a_ctrl_reg[0][CAU_LSB +: 2] == ACT_TOGGLE)
        |=> generator_first_output[0] != $past(generator_first_output[0]))
        else $error("cmp A upward action missed on A0");

    // Compare B upward drives A0 high in up/down counting
    a_cmpb_up_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[0].zero && !gen_evt[0].load && !gen_evt[0].cmp_a && gen_evt[0].cmp_b
         && mode_reg[0] && gen_evt[0].dir_up && a_ctrl_reg[0][CBU_LSB +: 2] == ACT_HIGH)
        |=> generator_first_output[0])
        else $error("cmp B upward action missed on A0");

    // Down-only counting ignores the direction and uses the downward field
    a_down_only: assert property (@(posedge pclk) disable iff (!presetn)
        (!gen_evt[0].zero && !gen_evt[0].load && gen_evt[0].cmp_a && !gen_evt[0].cmp_b
         && !mode_reg[0] && gen_evt[0].dir_up && a_ctrl_reg[0][CAD_LSB +: 2] == ACT_HIGH)
        |=> generator_first_output[0])
        else $error("down mode used upward field on A0");

    // No event on generator 2 holds A2
    a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (gen_evt[2] == '0) |=> $stable(generator_first_output[2]))
        else $error("A2 changed with no event");

    // A write to the B1 control lands in the access phase
    a_reg_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == GEN1_B_OFF)
        |=> b_ctrl_reg[1] == $past(pwdata[CTRL_W-1:0]))
        else $error("B1 control write lost");

    // A write to the mode bits lands in the access phase
    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == MODE_OFF)
        |=> mode_reg == $past(pwdata[2:0]))
        else $error("mode write lost");

    // A setup phase is answered with ready in the next cycle
    a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("ready missing in access phase");

    // No ready without a selected transfer
    a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (!psel) |=> !pready)
        else $error("ready raised while idle");

    // A status read shows the output levels of its setup cycle
    a_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OUT_STAT_OFF)
        |=> prdata[5:0] == {$past(generator_second_output),
                            $past(generator_first_output)})
        else $error("status read does not match outputs");

    // Reserved control bits read zero
    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == GEN1_A_OFF)
        |=> prdata[31:CTRL_W] == '0)
        else $error("reserved control bits not zero");
endmodule : pwmoal_top

//--- sim/pwmoal_top_tb.sv
// Purpose: Self-checking bench for the PWM output action logic
// Assumes: Zero-wait APB slave, one-cycle event pulses, registered outputs
// Notes:   Expected levels are worked out by hand from the action codes
`timescale 1ns/1ns
module pwmoal_top_tb;
    import pwmoal_pkg::*;
    logic              pclk    = 1'b0;  // Bus and event clock
    logic              presetn = 1'b0;  // Reset, low
    logic              psel    = 1'b0;  // APB select
    logic              penable = 1'b0;  // APB enable
    logic              pwrite  = 1'b0;  // APB direction
    logic [11:0]       paddr   = 12'h000; // APB address
    logic [31:0]       pwdata  = 32'h0; // APB write data
    logic [31:0]       prdata;          // APB read data
    logic              pready;          // APB ready
    logic              pslverr;         // APB error
    pwmoal_evt_t [2:0] gen_evt = '0;    // Event pulses
    logic [2:0]        out_a;           // A outputs
    logic [2:0]        out_b;           // B outputs
    logic [31:0]       rd;              // Last read word
    int                mismatches = 0;  // Failed compares
    int                compares   = 0;  // All compares
    pwmoal_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gen_evt(gen_evt), .generator_first_output(out_a),
        .generator_second_output(out_b));
    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;
    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; request held until pready is sampled high at a rising edge,
    // read data taken at that same edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One-cycle event pulse, then settle past the edge that acts on it
    task automatic pulse(input int g, input logic [4:0] e);
        @(posedge pclk);
        gen_evt[g] <= e;
        @(posedge pclk);
        gen_evt[g] <= '0;
        #1;
    endtask : pulse
    // Reset values of registers and outputs
    task automatic t_reset();
        logic [11:0] offs [5] = '{GEN0_B_OFF, GEN1_B_OFF, GEN2_B_OFF, GEN0_A_OFF, MODE_OFF};
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0);
            check("reset reg", rd, 32'h0);
        end
        check("reset outs", {out_a, out_b}, 32'h0);
        $display("done t_reset");
    endtask : t_reset
    // Every code on the zero event of the gen 0 B output
    task automatic t_codes();
        logic [1:0] code [5] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h0};
        logic       exp  [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        foreach (code[i]) begin
            apb(1'b1, GEN0_B_OFF, {30'h0, code[i]});
            pulse(0, 5'b10000);
            check("b0 zero", out_b[0], exp[i]);
            check("a0 idle", out_a[0], 1'b0);
        end
        $display("done t_codes");
    endtask : t_codes
    // Zero and load on A1/B1, load beats a coinciding compare, then compare B down alone
    task automatic t_load();
        apb(1'b1, GEN1_B_OFF, 32'h0000080C);
        apb(1'b1, GEN1_A_OFF, 32'h0000000B);
        pulse(1, 5'b10000);
        check("a1 zero", out_a[1], 1'b1);
        check("b1 zero keep", out_b[1], 1'b0);
        pulse(1, 5'b01010);
        check("b1 load", out_b[1], 1'b1);
        check("a1 load", out_a[1], 1'b0);
        pulse(1, 5'b00010);
        check("b1 cmpb down", out_b[1], 1'b0);
        check("a1 cmpb keep", out_a[1], 1'b0);
        $display("done t_load");
    endtask : t_load
    // Coinciding compares: B output takes B, A output takes A
    task automatic t_prio();
        apb(1'b1, GEN2_B_OFF, 32'h00000C80);
        apb(1'b1, GEN2_A_OFF, 32'h000008C0);
        pulse(2, 5'b00110);
        check("b2 prio", out_b[2], 1'b1);
        check("a2 prio", out_a[2], 1'b1);
        $display("done t_prio");
    endtask : t_prio
    // Upward fields only in up/down mode
    task automatic t_updown();
        apb(1'b1, GEN0_A_OFF, 32'h000003D0);
        apb(1'b1, MODE_OFF, 32'h00000001);
        apb(1'b0, MODE_OFF, 32'h0);
        check("mode", rd, 32'h1);
        pulse(0, 5'b00101);
        check("a0 up 1", out_a[0], 1'b1);
        pulse(0, 5'b00101);
        check("a0 up 2", out_a[0], 1'b0);
        pulse(0, 5'b00011);
        check("a0 cmpb up", out_a[0], 1'b1);
        apb(1'b1, GEN0_A_OFF, 32'h000003E2);
        pulse(0, 5'b10101);
        check("a0 zero wins", out_a[0], 1'b0);
        apb(1'b1, MODE_OFF, 32'h00000000);
        pulse(0, 5'b00101);
        check("a0 down mode", out_a[0], 1'b1);
        $display("done t_updown");
    endtask : t_updown
    // Implemented width of control words and unmapped space
    task automatic t_regs();
        apb(1'b0, OUT_STAT_OFF, 32'h0);
        check("out status", rd, 32'h00000025);
        apb(1'b1, GEN1_A_OFF, 32'hFFFFFFFF);
        apb(1'b0, GEN1_A_OFF, 32'h0);
        check("ctrl width", rd, 32'h00000FFF);
        apb(1'b1, 12'h200, 32'hFFFFFFFF);
        apb(1'b0, 12'h200, 32'h0);
        check("unmapped", rd, 32'h0);
        check("slverr", pslverr, 1'b0);
        $display("done t_regs");
    endtask : t_regs
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_codes();
        t_load();
        t_prio();
        t_updown();
        t_regs();
        print_verdict();
    end
    // Watchdog against a hung handshake
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
endmodule : pwmoal_top_tb
